// ### testbench/encnmt_master.sv
// far-side master model: takes offered frames, can stall the handshake
// assumes stall changes off the rising edge
`timescale 1ns/10ps
`default_nettype none

module encnmt_master (
  input  wire logic                      clock,
  input  wire logic                      stall,
  input  wire logic                      tx_valid,
  input  wire encnmt_pkg::encnmt_frame_t tx_frame,
  output var  logic                      tx_ready,
  output var  encnmt_pkg::encnmt_frame_t got_frame,
  output var  int                        n_got
);
  initial
  begin
    n_got = 0;
    tx_ready = 1'b0;
  end

  // ready moves just after the edge, like a real controller's mailbox
  always @(posedge clock)
  begin
    tx_ready <= !stall;
    if (tx_valid && tx_ready)
    begin
      got_frame <= tx_frame;
      n_got <= n_got + 1;
    end
  end
endmodule

`default_nettype wire

// ### testbench/encnmt_node_assertions.sv
// checker for the encoder node: state moves, boot-up, frame hold and store answers
// assumes it is bound to encnmt_node and sees only that module's ports
`timescale 1ns/10ps
`default_nettype none

module encnmt_node_chk #(
  parameter int CYC_PER_MS = encnmt_pkg::CYC_PER_MS
) (
  input wire logic                      clock,
  input wire logic                      sys_rst,
  input wire logic                      ce,
  input wire logic                      rx_valid,
  input wire encnmt_pkg::encnmt_frame_t rx_frame,
  input wire logic                      tx_ready,
  input wire logic                      tx_valid,
  input wire encnmt_pkg::encnmt_frame_t tx_frame,
  input wire logic [6:0]                nv_station,
  input wire logic                      nv_store,
  input wire logic                      app_reset,
  input wire encnmt_pkg::encnmt_node_t  node_state
);
  // ****************************************
  // working station copy and decoded requests
  // ****************************************
  logic [6:0] stn_reg;
  logic       nmt_ok;
  logic       nmt_hit;
  logic       nmt_miss;
  logic       store_req;

  // the station only follows the pins while initialising, later writes wait
  always_ff @(posedge clock)
    if (ce && node_state == encnmt_pkg::ST_INIT)
      stn_reg <= nv_station;

  assign nmt_ok = ce && rx_valid && rx_frame.id == encnmt_pkg::ID_NMT && !rx_frame.rtr && rx_frame.dlc >= 4'h2
                  && node_state != encnmt_pkg::ST_INIT;
  assign nmt_hit = nmt_ok && (rx_frame.data[1] == 8'h00 || rx_frame.data[1] == {1'b0, stn_reg});
  assign nmt_miss = nmt_ok && !(rx_frame.data[1] == 8'h00 || rx_frame.data[1] == {1'b0, stn_reg});
  assign store_req = ce && rx_valid && rx_frame.id == (encnmt_pkg::ID_SDO_RX | {4'h0, stn_reg}) && !rx_frame.rtr
                     && rx_frame.dlc == 4'h8 && rx_frame.data[3:0] == 32'h01101022
                     && (node_state == encnmt_pkg::ST_PREOP || node_state == encnmt_pkg::ST_OPER);

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // ****************************************
  // assertions
  // ****************************************
  AST_RESET_IDLE:
    assert property ($fell(sys_rst) && $past(ce) |-> node_state == encnmt_pkg::ST_INIT && !tx_valid && !nv_store)
      else $error("node not idle after reset");
  AST_BOOT:
    assert property (ce && node_state == encnmt_pkg::ST_INIT |=> node_state == encnmt_pkg::ST_PREOP && tx_valid
                     && tx_frame.id == (encnmt_pkg::ID_BOOT | {4'h0, stn_reg}) && tx_frame.dlc == 4'h1)
      else $error("no boot-up frame after init");
  AST_HOLD:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
      else $error("offered frame changed before taken");
  AST_START:
    assert property (nmt_hit && rx_frame.data[0] == 8'h01 |=> node_state == encnmt_pkg::ST_OPER)
      else $error("start command not obeyed");
  AST_STOP:
    assert property (nmt_hit && rx_frame.data[0] == 8'h02 |=> node_state == encnmt_pkg::ST_STOP)
      else $error("stop command not obeyed");
  AST_PREOP:
    assert property (nmt_hit && rx_frame.data[0] == 8'h80 |=> node_state == encnmt_pkg::ST_PREOP)
      else $error("pre-operational command not obeyed");
  AST_RESET_CMD:
    assert property (nmt_hit && (rx_frame.data[0] == 8'h81 || rx_frame.data[0] == 8'h82) |=>
                     node_state == encnmt_pkg::ST_INIT && app_reset == ($past(rx_frame.data[0]) == 8'h81))
      else $error("reset command not obeyed");
  AST_IGNORE:
    assert property (nmt_miss |=> $stable(node_state) && !app_reset)
      else $error("command for other station obeyed");
  AST_NO_PDO:
    assert property ($rose(tx_valid) && node_state != encnmt_pkg::ST_OPER && $past(node_state) != encnmt_pkg::ST_OPER
                     |-> tx_frame.id[10:7] != 4'h3)
      else $error("process data sent outside operational");
  AST_BADSIG:
    assert property (store_req && rx_frame.data[7:4] != 32'h65766173 |=> !nv_store)
      else $error("store with wrong signature written");
  AST_STORE:
    assert property (store_req && rx_frame.data[7:4] == 32'h65766173 && !tx_valid |=> nv_store && tx_valid
                     && tx_frame.data == 64'h01101060)
      else $error("store not confirmed");

  COV_START: cover property (nmt_hit && rx_frame.data[0] == 8'h01);
  COV_STORE: cover property (nv_store);
  COV_NODE_RST: cover property (app_reset);
endmodule

bind encnmt_node encnmt_node_chk #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.clock, .sys_rst, .ce, .rx_valid, .rx_frame,
  .tx_ready, .tx_valid, .tx_frame, .nv_station, .nv_store, .app_reset, .node_state);

`default_nettype wire

// ### testbench/encnmt_node_tb.sv
// testbench for the encoder node: management commands, store, polled, sync and cyclic sends
// assumes the master model in encnmt_master.sv and the bound checker
`timescale 1ns/10ps
`default_nettype none

module encnmt_node_tb;
  logic                      clock;
  logic                      sys_rst;
  logic                      rx_valid;
  logic                      stall;
  logic                      tx_valid;
  logic                      tx_ready;
  logic                      nv_store;
  logic                      app_reset;
  encnmt_pkg::encnmt_frame_t rx_frame;
  encnmt_pkg::encnmt_frame_t tx_frame;
  encnmt_pkg::encnmt_frame_t got;
  encnmt_pkg::encnmt_node_t  node_state;
  logic [31:0]               position;
  logic [31:0]               nv_preset;
  logic [6:0]                nv_station;
  logic [16:0]               nv_cycle_ms;
  logic [7:0]                nv_sync_skip;
  int                        n_got;
  int                        bad_count;
  int                        n_compared;
  int                        cyc;
  int                        n_store;
  int                        n_app;
  int                        k;

  encnmt_node #(.CYC_PER_MS(10)) u_encnmt_node (.clock(clock), .sys_rst(sys_rst), .ce(1'b1), .rx_valid(rx_valid),
    .rx_frame(rx_frame), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_frame(tx_frame), .position(position),
    .nv_station(nv_station), .nv_cycle_ms(nv_cycle_ms), .nv_sync_skip(nv_sync_skip), .nv_preset(nv_preset),
    .nv_store(nv_store), .app_reset(app_reset), .node_state(node_state));
  encnmt_master u_encnmt_master (.clock(clock), .stall(stall), .tx_valid(tx_valid), .tx_frame(tx_frame),
    .tx_ready(tx_ready), .got_frame(got), .n_got(n_got));

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ****************************************
  // pulse counters and hang guard
  // ****************************************
  always @(posedge clock)
  begin
    cyc++;
    n_store += int'(nv_store === 1'b1);
    n_app += int'(app_reset === 1'b1);
    if (cyc == 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc, input logic [63:0] d);
    @(negedge clock);
    rx_frame = {id, rtr, dlc, d};
    rx_valid = 1'b1;
    @(negedge clock);
    rx_valid = 1'b0;
  endtask

  // bytes past the length are not compared, the node may leave them at any value
  task automatic expect_frame(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
    int          k0;
    logic [63:0] m;
    k0 = n_got;
    m = ~64'h0 >> (7'd64 - {dlc, 3'b000});
    repeat (300) if (n_got == k0) @(posedge clock);
    #1;
    check("tx_count", 64'(n_got - k0), 64'h1);
    check("tx_id", 64'(got.id), 64'(id));
    check("tx_dlc", 64'(got.dlc), 64'(dlc));
    check("tx_data", got.data & m, d);
  endtask

  task automatic count_frames(input int cycles, input int exp);
    k = n_got;
    repeat (cycles) @(posedge clock);
    #1;
    check("frame_count", 64'(n_got - k), 64'(exp));
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    sys_rst = 1'b1;
    rx_valid = 1'b0;
    rx_frame = '0;
    stall = 1'b0;
    position = 32'h1234;
    nv_station = 7'h05;
    nv_cycle_ms = 17'h0;
    nv_sync_skip = 8'h01;
    nv_preset = 32'h64;
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    expect_frame(11'h705, 4'h1, 64'h0);
    check("state", 64'(node_state), 64'h2);
    send(11'h185, 1'b1, 4'h0, 64'h0);
    send(11'h080, 1'b0, 4'h0, 64'h0);
    count_frames(30, 0);
    send(11'h605, 1'b0, 4'h8, 64'h65766173_01101022);
    expect_frame(11'h585, 4'h8, 64'h00000000_01101060);
    check("store_pulses", 64'(n_store), 64'h1);
    send(11'h605, 1'b0, 4'h8, 64'h66766173_01101022);
    expect_frame(11'h585, 4'h8, 64'h08000020_01101080);
    send(11'h605, 1'b0, 4'h8, 64'h00000e10_00600122);
    expect_frame(11'h585, 4'h8, 64'h06020000_00600180);
    check("store_pulses", 64'(n_store), 64'h1);
    send(11'h000, 1'b0, 4'h2, 64'h0901);
    check("state", 64'(node_state), 64'h2);
    send(11'h000, 1'b0, 4'h2, 64'h0001);
    check("state", 64'(node_state), 64'h4);
    stall = 1'b1;
    send(11'h185, 1'b1, 4'h0, 64'h0);
    repeat (5) @(negedge clock);
    check("held_valid", 64'(tx_valid), 64'h1);
    stall = 1'b0;
    expect_frame(11'h185, 4'h4, 64'h1298);
    k = n_got;
    repeat (4) send(11'h080, 1'b0, 4'h0, 64'h0);
    repeat (20) @(posedge clock);
    #1;
    check("sync_answers", 64'(n_got - k), 64'h2);
    @(negedge clock);
    nv_station = 7'h06;
    nv_cycle_ms = 17'h2;
    send(11'h185, 1'b1, 4'h0, 64'h0);
    expect_frame(11'h185, 4'h4, 64'h1298);
    send(11'h000, 1'b0, 4'h2, 64'h0582);
    expect_frame(11'h706, 4'h1, 64'h0);
    check("node_resets", 64'(n_app), 64'h0);
    send(11'h000, 1'b0, 4'h2, 64'h0601);
    k = n_got;
    repeat (100) @(posedge clock);
    #1;
    check("cyclic_sends", 64'((n_got - k) inside {4, 5}), 64'h1);
    check("cyclic_id", 64'(got.id), 64'h186);
    send(11'h000, 1'b0, 4'h2, 64'h0602);
    check("state", 64'(node_state), 64'h8);
    repeat (3) @(negedge clock);
    send(11'h606, 1'b0, 4'h8, 64'h65766173_01101022);
    count_frames(60, 0);
    check("store_pulses", 64'(n_store), 64'h1);
    send(11'h000, 1'b0, 4'h2, 64'h0080);
    check("state", 64'(node_state), 64'h2);
    nv_cycle_ms = 17'h0;
    send(11'h000, 1'b0, 4'h2, 64'h0081);
    expect_frame(11'h706, 4'h1, 64'h0);
    check("node_resets", 64'(n_app), 64'h1);
    send(11'h000, 1'b0, 4'h2, 64'h0001);
    count_frames(100, 0);
    wrap_up();
  end
endmodule

`default_nettype wire

// ### verilog/encnmt_node.sv
// encoder node: network-management states, boot-up, store command, position transmission
// assumes a CAN controller that hands over whole received frames and takes one frame per handshake
`timescale 1ns/10ps
`default_nettype none

module encnmt_node #(
  parameter int CYC_PER_MS = encnmt_pkg::CYC_PER_MS
) (
  input  wire logic                                 clock,
  input  wire logic                                 sys_rst,
  input  wire logic                                 ce,
  input  wire logic                                 rx_valid,
  input  wire encnmt_pkg::encnmt_frame_t            rx_frame,
  input  wire logic                                 tx_ready,
  output var  logic                                 tx_valid,
  output var  encnmt_pkg::encnmt_frame_t            tx_frame,
  input  wire logic [encnmt_pkg::POS_W-1:0]         position,
  input  wire logic [encnmt_pkg::STN_W-1:0]         nv_station,
  input  wire logic [encnmt_pkg::PERIOD_W-1:0]      nv_cycle_ms,
  input  wire logic [encnmt_pkg::SKIP_W-1:0]        nv_sync_skip,
  input  wire logic [encnmt_pkg::POS_W-1:0]         nv_preset,
  output var  logic                                 nv_store,
  output var  logic                                 app_reset,
  output var  encnmt_pkg::encnmt_node_t             node_state
);

  // ***********************************************
  // state
  // ***********************************************
  typedef struct packed {
    encnmt_pkg::encnmt_node_t             st;
    logic [encnmt_pkg::STN_W-1:0]         station;
    logic [encnmt_pkg::PERIOD_W-1:0]      period;
    logic [encnmt_pkg::PERIOD_W-1:0]      ms_cnt;
    logic [encnmt_pkg::SKIP_W-1:0]        skip;
    logic [encnmt_pkg::SKIP_W-1:0]        skip_cnt;
    logic [encnmt_pkg::POS_W-1:0]         preset;
    logic                                 boot_pend;
    logic                                 pdo_pend;
    logic [encnmt_pkg::POS_W-1:0]         pdo_pos;
    logic                                 sdo_pend;
    encnmt_pkg::encnmt_frame_t            sdo_frm;
    logic                                 tx_valid;
    encnmt_pkg::encnmt_frame_t            tx_frm;
    logic                                 nv_store;
    logic                                 app_reset;
  } encnmt_core_t;

  encnmt_core_t core_reg;
  encnmt_core_t core_next;
  logic         ms_tick;

  encnmt_tick #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_tick (
    .clock   (clock),
    .sys_rst (sys_rst),
    .ce      (ce),
    .tick    (ms_tick)
  );

  // ***********************************************
  // frame decode
  // ***********************************************
  logic [7:0]  stn_byte;
  logic [10:0] stn_id;
  logic        nmt_addr_ok;
  logic        nmt_hit;
  logic        sdo_hit;
  logic        rtr_hit;
  logic        sync_hit;
  logic [15:0] rx_index;
  logic [7:0]  rx_sub;
  logic [31:0] rx_word;
  logic [encnmt_pkg::POS_W-1:0] pos_scaled;

  assign stn_byte = {1'b0, core_reg.station};
  assign stn_id   = {4'h0, core_reg.station};
  assign rx_index = {rx_frame.data[2], rx_frame.data[1]};
  assign rx_sub   = rx_frame.data[3];
  assign rx_word  = {rx_frame.data[7], rx_frame.data[6], rx_frame.data[5], rx_frame.data[4]};
  // offset stands in for the configured scaling
  assign pos_scaled = position + core_reg.preset;

  // broadcast or own station; anything else passes by untouched
  assign nmt_addr_ok = rx_frame.data[1] == encnmt_pkg::NMT_BCAST
                       || rx_frame.data[1] == stn_byte;

  assign nmt_hit = rx_valid && !rx_frame.rtr && rx_frame.id == encnmt_pkg::ID_NMT
                   && rx_frame.dlc >= encnmt_pkg::DLC_NMT && nmt_addr_ok;

  assign sdo_hit = rx_valid && !rx_frame.rtr && rx_frame.dlc == encnmt_pkg::DLC_SDO
                   && rx_frame.id == encnmt_pkg::ID_SDO_RX + stn_id;

  assign rtr_hit = rx_valid && rx_frame.rtr && rx_frame.id == encnmt_pkg::ID_TPDO1 + stn_id;

  assign sync_hit = rx_valid && !rx_frame.rtr && rx_frame.id == encnmt_pkg::ID_SYNC;

  // ***********************************************
  // next state
  // ***********************************************
  always_comb
  begin
    core_next = core_reg;
    core_next.nv_store = 1'b0;
    core_next.app_reset = 1'b0;

    if (core_reg.tx_valid && tx_ready)
    begin
      core_next.tx_valid = 1'b0;
    end

    case (core_reg.st)
      encnmt_pkg::ST_INIT:
      begin
        // working copy only changes here, so fresh network settings wait for a reset
        core_next.station = nv_station;
        core_next.period = nv_cycle_ms;
        core_next.skip = nv_sync_skip;
        core_next.preset = nv_preset;
        // counters restart so a reset never inherits a half-run period
        core_next.ms_cnt = '0;
        core_next.skip_cnt = '0;
        core_next.pdo_pend = 1'b0;
        core_next.sdo_pend = 1'b0;
        core_next.boot_pend = 1'b1;
        core_next.st = encnmt_pkg::ST_PREOP;
      end

      encnmt_pkg::ST_PREOP,
      encnmt_pkg::ST_OPER,
      encnmt_pkg::ST_STOP:
      begin
        // ***** SDO service, silent when stopped *****
        // a newer request overwrites an unsent reply, the older one is lost
        if (sdo_hit && core_reg.st != encnmt_pkg::ST_STOP)
        begin
          core_next.sdo_pend = 1'b1;
          core_next.sdo_frm.id = encnmt_pkg::ID_SDO_TX + stn_id;
          core_next.sdo_frm.rtr = 1'b0;
          core_next.sdo_frm.dlc = encnmt_pkg::DLC_SDO;
          core_next.sdo_frm.data[1] = rx_frame.data[1];
          core_next.sdo_frm.data[2] = rx_frame.data[2];
          core_next.sdo_frm.data[3] = rx_frame.data[3];
          if (rx_frame.data[0] == encnmt_pkg::SDO_DL_REQ && rx_index == encnmt_pkg::IDX_STORE
              && rx_sub == encnmt_pkg::SUB_STORE)
          begin
            if (rx_word == encnmt_pkg::SIG_SAVE)
            begin
              core_next.nv_store = 1'b1;
              core_next.sdo_frm.data[0] = encnmt_pkg::SDO_DL_ACK;
              {core_next.sdo_frm.data[7], core_next.sdo_frm.data[6],
               core_next.sdo_frm.data[5], core_next.sdo_frm.data[4]} = 32'h00000000;
            end
            else
            begin
              core_next.sdo_frm.data[0] = encnmt_pkg::SDO_ABORT;
              {core_next.sdo_frm.data[7], core_next.sdo_frm.data[6],
               core_next.sdo_frm.data[5], core_next.sdo_frm.data[4]} = encnmt_pkg::ABORT_NOSTORE;
            end
          end
          else
          begin
            // only the store object is served by this block
            core_next.sdo_frm.data[0] = encnmt_pkg::SDO_ABORT;
            {core_next.sdo_frm.data[7], core_next.sdo_frm.data[6],
             core_next.sdo_frm.data[5], core_next.sdo_frm.data[4]} = encnmt_pkg::ABORT_NOOBJ;
          end
        end

        // ***** process data, operational only *****
        if (core_reg.st == encnmt_pkg::ST_OPER)
        begin
          // a newer trigger replaces a queued position, the host gets the latest
          if (rtr_hit)
          begin
            core_next.pdo_pend = 1'b1;
            core_next.pdo_pos = pos_scaled;
          end
          if (sync_hit)
          begin
            // first answer after start on sync skip+1, then every skip+1 syncs
            if (core_reg.skip_cnt >= core_reg.skip)
            begin
              core_next.skip_cnt = '0;
              core_next.pdo_pend = 1'b1;
              core_next.pdo_pos = pos_scaled;
            end
            else
            begin
              core_next.skip_cnt = core_reg.skip_cnt + encnmt_pkg::SKIP_W'(1);
            end
          end
          // tick phase runs free, so the first send lands period-1..period ms after start
          if (core_reg.period != '0 && ms_tick)
          begin
            if (core_reg.ms_cnt + encnmt_pkg::PERIOD_W'(1) >= core_reg.period)
            begin
              core_next.ms_cnt = '0;
              core_next.pdo_pend = 1'b1;
              core_next.pdo_pos = pos_scaled;
            end
            else
            begin
              core_next.ms_cnt = core_reg.ms_cnt + encnmt_pkg::PERIOD_W'(1);
            end
          end
        end

        // ***** management commands, obeyed in every running state *****
        if (nmt_hit)
        begin
          case (rx_frame.data[0])
            encnmt_pkg::NMT_START:
            begin
              core_next.st = encnmt_pkg::ST_OPER;
              core_next.ms_cnt = '0;
              core_next.skip_cnt = '0;
            end
            encnmt_pkg::NMT_STOP:
            begin
              core_next.st = encnmt_pkg::ST_STOP;
            end
            encnmt_pkg::NMT_PREOP:
            begin
              core_next.st = encnmt_pkg::ST_PREOP;
            end
            encnmt_pkg::NMT_RST_COMM:
            begin
              core_next.st = encnmt_pkg::ST_INIT;
            end
            encnmt_pkg::NMT_RST_NODE:
            begin
              core_next.app_reset = 1'b1;
              core_next.st = encnmt_pkg::ST_INIT;
            end
            // unknown command bytes leave the state alone
            default:
            begin
              core_next.st = core_reg.st;
            end
          endcase
        end

        // a position still queued when leaving operational is dropped
        if (core_next.st != encnmt_pkg::ST_OPER)
        begin
          core_next.pdo_pend = 1'b0;
        end
      end

      default:
      begin
        core_next.st = encnmt_pkg::ST_INIT;
      end
    endcase

    // ***** transmit slot: boot-up first, then SDO reply, then position *****
    if (!core_next.tx_valid)
    begin
      if (core_next.boot_pend)
      begin
        core_next.boot_pend = 1'b0;
        core_next.tx_valid = 1'b1;
        core_next.tx_frm = '0;
        core_next.tx_frm.id = encnmt_pkg::ID_BOOT + {4'h0, core_next.station};
        core_next.tx_frm.dlc = encnmt_pkg::DLC_BOOT;
      end
      else if (core_next.sdo_pend)
      begin
        core_next.sdo_pend = 1'b0;
        core_next.tx_valid = 1'b1;
        core_next.tx_frm = core_next.sdo_frm;
      end
      else if (core_next.pdo_pend)
      begin
        core_next.pdo_pend = 1'b0;
        core_next.tx_valid = 1'b1;
        core_next.tx_frm = '0;
        // identifier carries the station, so arbitration orders sync answers
        core_next.tx_frm.id = encnmt_pkg::ID_TPDO1 + {4'h0, core_next.station};
        core_next.tx_frm.dlc = encnmt_pkg::DLC_POS;
        core_next.tx_frm.data[0] = core_next.pdo_pos[7:0];
        core_next.tx_frm.data[1] = core_next.pdo_pos[15:8];
        core_next.tx_frm.data[2] = core_next.pdo_pos[23:16];
        core_next.tx_frm.data[3] = core_next.pdo_pos[31:24];
      end
    end
  end

  // ***********************************************
  // registers
  // ***********************************************
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      core_reg <= '0;
      // nv pins are copied in the init cycle that follows, not here
      core_reg.st <= encnmt_pkg::ST_INIT;
    end
    else if (ce)
    begin
      core_reg <= core_next;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  assign tx_valid   = core_reg.tx_valid;
  assign tx_frame   = core_reg.tx_frm;
  assign nv_store   = core_reg.nv_store;
  assign app_reset  = core_reg.app_reset;
  assign node_state = core_reg.st;

endmodule

`default_nettype wire

// ### verilog/encnmt_pkg.sv
// network-management and position-transmission constants for the encoder node
// assumes 11-bit identifiers and a frame carrier shared with the CAN controller
package encnmt_pkg;

  // ***********************************************
  // identifiers and widths
  // ***********************************************
  localparam int STN_W    = 7;
  localparam int PERIOD_W = 17;
  localparam int SKIP_W   = 8;
  localparam int POS_W    = 32;

  localparam logic [10:0] ID_NMT    = 11'h000;
  localparam logic [10:0] ID_SYNC   = 11'h080;
  localparam logic [10:0] ID_TPDO1  = 11'h180;
  localparam logic [10:0] ID_SDO_TX = 11'h580;
  localparam logic [10:0] ID_SDO_RX = 11'h600;
  localparam logic [10:0] ID_BOOT   = 11'h700;

  // ***********************************************
  // network-management commands
  // ***********************************************
  localparam logic [7:0] NMT_START    = 8'h01;
  localparam logic [7:0] NMT_STOP     = 8'h02;
  localparam logic [7:0] NMT_PREOP    = 8'h80;
  localparam logic [7:0] NMT_RST_NODE = 8'h81;
  localparam logic [7:0] NMT_RST_COMM = 8'h82;
  localparam logic [7:0] NMT_BCAST    = 8'h00;

  // ***********************************************
  // SDO fields
  // ***********************************************
  localparam logic [7:0]  SDO_DL_REQ    = 8'h22;
  localparam logic [7:0]  SDO_DL_ACK    = 8'h60;
  localparam logic [7:0]  SDO_ABORT     = 8'h80;
  localparam logic [15:0] IDX_STORE     = 16'h1010;
  localparam logic [7:0]  SUB_STORE     = 8'h01;
  // bytes 4..7 = 73h 61h 76h 65h, byte 4 in the low lane
  localparam logic [31:0] SIG_SAVE      = 32'h65766173;
  localparam logic [31:0] ABORT_NOSTORE = 32'h08000020;
  localparam logic [31:0] ABORT_NOOBJ   = 32'h06020000;

  localparam logic [3:0] DLC_SDO  = 4'h8;
  localparam logic [3:0] DLC_POS  = 4'h4;
  localparam logic [3:0] DLC_BOOT = 4'h1;
  localparam logic [3:0] DLC_NMT  = 4'h2;

  // ***********************************************
  // timing
  // ***********************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS       = 1000000;
  localparam int CYC_PER_MS    = TICK_NS / CLK_PERIOD_NS;

  // ***********************************************
  // types
  // ***********************************************
  typedef struct packed {
    logic [10:0]     id;
    logic            rtr;
    logic [3:0]      dlc;
    logic [7:0][7:0] data;
  } encnmt_frame_t;

  typedef enum logic [3:0] {
    ST_INIT  = 4'b0001,
    ST_PREOP = 4'b0010,
    ST_OPER  = 4'b0100,
    ST_STOP  = 4'b1000
  } encnmt_node_t;

endpackage

// ### verilog/encnmt_tick.sv
// millisecond tick generator for the cyclic position timer
// assumes a free-running system clock gated by the common clock enable
`timescale 1ns/10ps
`default_nettype none

module encnmt_tick #(
  parameter int CYC_PER_MS = encnmt_pkg::CYC_PER_MS
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic ce,
  output var  logic tick
);

  localparam int CNT_W = $clog2(CYC_PER_MS + 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } encnmt_tick_st_t;

  encnmt_tick_st_t tick_reg;
  encnmt_tick_st_t tick_next;

  always_comb
  begin
    tick_next = tick_reg;
    tick_next.tick = 1'b0;
    if (tick_reg.cnt == CNT_W'(CYC_PER_MS - 1))
    begin
      tick_next.cnt = '0;
      tick_next.tick = 1'b1;
    end
    else
    begin
      tick_next.cnt = tick_reg.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      tick_reg <= '0;
    end
    else if (ce)
    begin
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg.tick;

endmodule

`default_nettype wire
